//--- sadc_pkg.sv
// Purpose: Shared constants and types for the SAR converter sequencer.
// Assumes: One clock, synchronous active-high reset, 8-bit registers.
// Notes:   Register indices are word indices; byte address is index * 4.

package sadc_pkg;

	// ---------------------------------------------------------------
	// Bus and register map
	// ---------------------------------------------------------------
	localparam int unsigned SADC_ADR_W = 8;
	localparam int unsigned SADC_DAT_W = 32;
	localparam logic [SADC_ADR_W-1:0] SADC_IDX_CTRL_ONE = 8'h1C;
	localparam logic [SADC_ADR_W-1:0] SADC_IDX_TIMING = 8'h1D;
	localparam logic [SADC_ADR_W-1:0] SADC_IDX_RES_LOW = 8'h1E;
	localparam logic [SADC_ADR_W-1:0] SADC_IDX_RES_HIGH = 8'h1F;
	localparam int unsigned SADC_IDX_LSB = 2;

	// ---------------------------------------------------------------
	// Field layouts and reset values
	// ---------------------------------------------------------------
	localparam int unsigned SADC_RES_W = 10;
	localparam int unsigned SADC_CNT_W = 11;
	localparam logic [1:0] SADC_MODE_OFF = 2'h0;
	localparam logic [1:0] SADC_MODE_SINGLE = 2'h1;
	localparam logic [1:0] SADC_MODE_REPEAT = 2'h3;
	localparam logic [7:0] SADC_CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] SADC_TIMING_RST = 8'h10;
	localparam logic [3:0] SADC_LOW_UNDEF = 4'h0;
	localparam logic [1:0] SADC_TIMING_UNDEF = 2'h0;
	localparam logic [3:0] SADC_CHAN_MAX = 4'h7;

	// Control register one: start, mode, input disable, channel.
	typedef struct packed {
		logic start;
		logic [1:0] mode;
		logic ain_dis;
		logic [3:0] chan;
	} sadc_ctrl_s;

	// Timing register: top bits, ladder select, fixed one, code, zero.
	typedef struct packed {
		logic [1:0] top;
		logic ladder;
		logic fixed_one;
		logic [2:0] time_code;
		logic fixed_zero;
	} sadc_timing_s;

	// ---------------------------------------------------------------
	// Conversion time in fc cycles
	// ---------------------------------------------------------------
	localparam logic [SADC_CNT_W-1:0] SADC_T39 = 11'h027;
	localparam logic [SADC_CNT_W-1:0] SADC_T78 = 11'h04E;
	localparam logic [SADC_CNT_W-1:0] SADC_T156 = 11'h09C;
	localparam logic [SADC_CNT_W-1:0] SADC_T312 = 11'h138;
	localparam logic [SADC_CNT_W-1:0] SADC_T624 = 11'h270;
	localparam logic [SADC_CNT_W-1:0] SADC_T1248 = 11'h4E0;

	// Reserved codes fall back to the longest time.
	function automatic logic [SADC_CNT_W-1:0] sadc_conv_cycles(
		input logic [2:0] code);
		case (code)
			3'h0: sadc_conv_cycles = SADC_T39;
			3'h2: sadc_conv_cycles = SADC_T78;
			3'h3: sadc_conv_cycles = SADC_T156;
			3'h4: sadc_conv_cycles = SADC_T312;
			3'h5: sadc_conv_cycles = SADC_T624;
			default: sadc_conv_cycles = SADC_T1248;
		endcase
	endfunction

endpackage

//--- sadc_conv_timer.sv
// Purpose: Counts the programmed conversion time and flags its end.
// Assumes: load_i is stable in the cycle start_i is high.
// Notes:   done_o is a one-cycle pulse; abort_i wins over completion.

module sadc_conv_timer import sadc_pkg::*; #(
	parameter int unsigned CNT_W = SADC_CNT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [CNT_W-1:0] load_i,
	// Status
	output logic running_o,
	output logic done_o
);

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic run_reg;
	logic run_next;
	logic last_w;

	// Last cycle of a running conversion.
	assign last_w = run_reg && (count_reg == {{(CNT_W-1){1'b0}}, 1'b1});
	// A start does not hide completion; gating on it would close a loop
	// through the repeat restart.
	assign done_o = last_w && !abort_i;
	assign running_o = run_reg;

	// Next-state of the down counter.
	always_comb begin
		count_next = count_reg;
		run_next = run_reg;
		if (abort_i) begin
			run_next = 1'b0;
		end else if (start_i) begin
			count_next = load_i;
			run_next = 1'b1;
		end else if (last_w) begin
			run_next = 1'b0;
		end else if (run_reg) begin
			count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Counter registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			run_reg <= run_next;
		end
	end

endmodule // sadc_conv_timer

//--- sadc_sar.sv
// Purpose: Successive-approximation register, one decision a cycle.
// Assumes: comp_i is high when the input is above the trial code.
// Notes:   Finishes long before the shortest conversion time ends.

module sadc_sar import sadc_pkg::*; #(
	parameter int unsigned RES_W = SADC_RES_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic start_i,
	input wire logic comp_i,
	// Trial code to the ladder and final value
	output logic [RES_W-1:0] trial_o
);

	logic [RES_W-1:0] code_reg;
	logic [RES_W-1:0] bit_reg;

	assign trial_o = code_reg | bit_reg;

	// Keep the trial bit when the comparator says input is higher.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_reg <= '0;
			bit_reg <= '0;
		end else if (start_i) begin
			code_reg <= '0;
			bit_reg <= {1'b1, {(RES_W-1){1'b0}}};
		end else if (bit_reg != '0) begin
			code_reg <= comp_i ? trial_o : code_reg;
			bit_reg <= bit_reg >> 1;
		end
	end

endmodule // sadc_sar

//--- sadc_seq.sv
// Purpose: Control, timing and result registers of a 10-bit SAR
//          converter, reached over a classic Wishbone slave.
// Assumes: standby_i is high while the chip is in stop, slow or sleep.
// Notes:   Each register answers one cycle after its request.

module sadc_seq import sadc_pkg::*; #(
	parameter int unsigned RES_W = SADC_RES_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [SADC_ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [SADC_DAT_W-1:0] dat_i,
	output logic [SADC_DAT_W-1:0] dat_o,
	output logic ack_o,
	// Chip power mode
	input wire logic standby_i,
	// Analog front end
	input wire logic comp_i,
	output logic [RES_W-1:0] trial_code_o,
	output logic [3:0] channel_select_o,
	output logic analog_input_disable_o,
	output logic ladder_connect_o,
	output logic sample_o,
	// Completion event
	output logic conversion_done_irq_o
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	typedef enum logic [0:0] {
		SADC_IDLE,
		SADC_CONVERT
	} sadc_state_e;

	sadc_state_e state_reg;
	sadc_state_e state_next;
	sadc_ctrl_s ctrl_reg;
	sadc_ctrl_s ctrl_next;
	sadc_ctrl_s ctrl_wr;
	sadc_timing_s timing_reg;
	sadc_timing_s timing_next;
	sadc_timing_s timing_wr;
	logic [RES_W-1:0] result_reg;
	logic [RES_W-1:0] result_next;
	logic eoc_reg;
	logic eoc_next;
	logic busy_reg;
	logic busy_next;
	logic irq_reg;
	logic ack_reg;
	logic [SADC_DAT_W-1:0] dat_reg;
	logic [SADC_DAT_W-1:0] rd_mux;
	localparam int unsigned IDX_W = SADC_ADR_W - SADC_IDX_LSB;
	logic [IDX_W-1:0] idx_w;
	logic req_w;
	logic take_w;
	logic wr_w;
	logic rd_w;
	logic hit_ctrl_w;
	logic hit_timing_w;
	logic hit_low_w;
	logic hit_high_w;
	logic wr_ctrl_w;
	logic wr_timing_w;
	logic rd_high_w;
	logic mode_run_w;
	logic start_w;
	logic restart_w;
	logic abort_w;
	logic conv_start_w;
	logic done_w;
	logic running_w;
	logic [7:0] status_byte;
	logic [7:0] timing_byte;
	logic [7:0] high_byte;
	logic [SADC_CNT_W-1:0] load_w;

	// ---------------------------------------------------------------
	// Wishbone decode
	// ---------------------------------------------------------------

	// Word index from the byte address; one access per request.
	assign idx_w = adr_i[SADC_ADR_W-1:SADC_IDX_LSB];
	assign req_w = cyc_i && stb_i;
	assign take_w = req_w && ack_reg;
	assign wr_w = take_w && we_i && sel_i[0];
	assign rd_w = take_w && !we_i;
	// The package holds word indices, so they compare at index width.
	assign hit_ctrl_w = idx_w == SADC_IDX_CTRL_ONE[IDX_W-1:0];
	assign hit_timing_w = idx_w == SADC_IDX_TIMING[IDX_W-1:0];
	assign hit_low_w = idx_w == SADC_IDX_RES_LOW[IDX_W-1:0];
	assign hit_high_w = idx_w == SADC_IDX_RES_HIGH[IDX_W-1:0];
	assign wr_ctrl_w = wr_w && hit_ctrl_w && !standby_i;
	assign wr_timing_w = wr_w && hit_timing_w && !standby_i;
	assign rd_high_w = rd_w && hit_high_w;
	assign ctrl_wr = sadc_ctrl_s'(dat_i[7:0]);
	assign timing_wr = sadc_timing_s'(dat_i[7:0]);

	// Read images of the registers.
	// status layout
	assign status_byte = {result_reg[1:0], eoc_reg, busy_reg,
		SADC_LOW_UNDEF};
	assign timing_byte = {SADC_TIMING_UNDEF, timing_reg[5:0]};
	assign high_byte = result_reg[RES_W-1:RES_W-8];
	assign rd_mux = hit_ctrl_w ? {24'h000000, ctrl_reg} :
		hit_timing_w ? {24'h000000, timing_byte} :
		hit_low_w ? {24'h000000, status_byte} :
		hit_high_w ? {24'h000000, high_byte} : '0;

	// Ack one cycle after the request; read data is captured with it.
	// Data is taken in the first cycle, before a read side effect lands
	// at the acknowledged edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= req_w && !ack_reg;
			dat_reg <= (req_w && !ack_reg) ? rd_mux : dat_reg;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// ---------------------------------------------------------------
	// Start, restart and abort decisions
	// ---------------------------------------------------------------

	assign mode_run_w = (ctrl_reg.mode == SADC_MODE_SINGLE) ||
		(ctrl_reg.mode == SADC_MODE_REPEAT);
	assign start_w = ctrl_reg.start && mode_run_w && !standby_i;
	// repeat restart
	// Only a conversion in flight may restart itself.
	assign restart_w = done_w && (state_reg == SADC_CONVERT) &&
		(ctrl_reg.mode == SADC_MODE_REPEAT) && !standby_i;
	// standby aborts
	// Abort outranks any start, so a cut conversion never stores.
	assign abort_w = standby_i || (ctrl_reg.mode == SADC_MODE_OFF);
	assign conv_start_w = (start_w || restart_w) && !abort_w;
	assign load_w = sadc_conv_cycles(timing_reg.time_code);

	// Conversion time counter.
	sadc_conv_timer #(
		.CNT_W(SADC_CNT_W)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(conv_start_w),
		.abort_i(abort_w),
		.load_i(load_w),
		.running_o(running_w),
		.done_o(done_w)
	);

	// Bit-decision engine driving the ladder.
	sadc_sar #(
		.RES_W(RES_W)
	) u_sar (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(conv_start_w),
		.comp_i(comp_i),
		.trial_o(trial_code_o)
	);

	// ---------------------------------------------------------------
	// Sequencer state
	// ---------------------------------------------------------------

	// Tracks whether a conversion is in flight.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SADC_IDLE: begin
				if (conv_start_w) begin
					state_next = SADC_CONVERT;
				end
			end
			SADC_CONVERT: begin
				// Abort ends it; a start in its last cycle keeps it going.
				if (abort_w) begin
					state_next = SADC_IDLE;
				end else if (done_w && !conv_start_w) begin
					state_next = SADC_IDLE;
				end
			end
			default: begin
				state_next = SADC_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------

	// Control register one next value.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl_w) begin
			ctrl_next = ctrl_wr;
		end
		if (conv_start_w && start_w) begin
			ctrl_next.start = 1'b0;
		end
		if (standby_i) begin
			ctrl_next = sadc_ctrl_s'(SADC_CTRL_ONE_RST);
		end
	end

	// Timing register next value.
	always_comb begin
		timing_next = timing_reg;
		if (wr_timing_w) begin
			timing_next = timing_wr;
		end
		if (standby_i) begin
			timing_next = sadc_timing_s'(SADC_TIMING_RST);
		end
	end

	// ---------------------------------------------------------------
	// Result and flags
	// ---------------------------------------------------------------

	// Result capture, done flag and busy flag.
	always_comb begin
		result_next = result_reg;
		eoc_next = eoc_reg;
		busy_next = busy_reg;
		if (rd_high_w) begin
			eoc_next = 1'b0;
		end
		if (conv_start_w) begin
			eoc_next = 1'b0;
		end
		if (conv_start_w) begin
			busy_next = 1'b1;
		end else if (done_w || abort_w) begin
			busy_next = 1'b0;
		end
		// Completion is applied after the clears, so its set wins over a clear in
		// the same cycle and a repeat restart still shows the result.
		// store and flag
		if (done_w && !abort_w) begin
			result_next = trial_code_o;
			eoc_next = 1'b1;
		end
		if (standby_i) begin
			result_next = '0;
			eoc_next = 1'b0;
			busy_next = 1'b0;
		end
	end

	// State and register updates.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= SADC_IDLE;
			ctrl_reg <= sadc_ctrl_s'(SADC_CTRL_ONE_RST);
			timing_reg <= sadc_timing_s'(SADC_TIMING_RST);
			result_reg <= '0;
			eoc_reg <= 1'b0;
			busy_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			timing_reg <= timing_next;
			result_reg <= result_next;
			eoc_reg <= eoc_next;
			busy_reg <= busy_next;
			irq_reg <= done_w && !abort_w;
		end
	end

	// ---------------------------------------------------------------
	// Front-end outputs
	// ---------------------------------------------------------------

	// Standby wins so that no current flows from the reference.
	// ladder while running or always
	assign ladder_connect_o = !standby_i &&
		(timing_reg.ladder || running_w);
	// Reserved codes show as the last valid input, never beyond it.
	// reserved channel codes
	assign channel_select_o = (ctrl_reg.chan > SADC_CHAN_MAX) ?
		SADC_CHAN_MAX : ctrl_reg.chan;
	assign analog_input_disable_o = ctrl_reg.ain_dis;
	// The sample pulse marks the start edge of every conversion.
	assign sample_o = conv_start_w;
	assign conversion_done_irq_o = irq_reg;

endmodule // sadc_seq

//--- sadc_seq_chk.sv
// Purpose: Port-level checks of the SAR converter sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the sequencer from the bench top file.

module sadc_seq_chk import sadc_pkg::*; #(
	parameter int unsigned RES_W = SADC_RES_W
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [SADC_ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [SADC_DAT_W-1:0] dat_i,
	input wire logic [SADC_DAT_W-1:0] dat_o,
	input wire logic ack_o,
	// Power mode and front end
	input wire logic standby_i,
	input wire logic comp_i,
	input wire logic [RES_W-1:0] trial_code_o,
	input wire logic [3:0] channel_select_o,
	input wire logic analog_input_disable_o,
	input wire logic ladder_connect_o,
	input wire logic sample_o,
	input wire logic conversion_done_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A read answered at one register slot.
	sequence s_rd(logic [5:0] idx);
		ack_o && !we_i && adr_i[7:2] == idx;
	endsequence
	// A request waiting for its answer.
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	// A start seen while awake for two cycles.
	sequence s_start;
		sample_o && !standby_i ##1 !standby_i;
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_ack_next: assert property (s_req |=> ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_stat_nib: assert property (s_rd(6'h1E) |-> dat_o[3:0] == 4'h0)
		else $error("status low nibble not zero");
	a_tim_top: assert property (s_rd(6'h1D) |-> dat_o[7:6] == 2'h0)
		else $error("timing top bits returned data");
	a_ladder_off: assert property (standby_i |-> !ladder_connect_o)
		else $error("ladder connected in standby");
	a_irq_pulse: assert property (conversion_done_irq_o
		|=> !conversion_done_irq_o)
		else $error("irq longer than one cycle");
	a_start_runs: assert property (s_start |-> ladder_connect_o)
		else $error("start did not run the converter");
	a_sleep_quiet: assert property (standby_i ##1 standby_i
		|-> !conversion_done_irq_o && !sample_o)
		else $error("activity during standby");
	a_chan_max: assert property (channel_select_o <= SADC_CHAN_MAX)
		else $error("channel beyond seven");

endmodule // sadc_seq_chk

//--- tb_sar_adc_sequencer_control.sv
// Purpose: Self-checking bench for the SAR converter sequencer.
// Assumes: Bus answer comes one cycle after a request.
// Notes:   The comparator is modelled from a target code.

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_sar_adc_sequencer_control import sadc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTL = 8'h70;
	localparam logic [7:0] A_TIM = 8'h74;
	localparam logic [7:0] A_STA = 8'h78;
	localparam logic [7:0] A_UP = 8'h7C;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic standby_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [9:0] target = 10'h000;
	logic comp_i;
	logic [31:0] dat_o;
	logic ack_o;
	logic [9:0] trial_code_o;
	logic [3:0] channel_select_o;
	logic analog_input_disable_o;
	logic ladder_connect_o;
	logic sample_o;
	logic conversion_done_irq_o;
	int fails = 0;
	int compares = 0;

	// Free-running clock at 40 MHz.
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// Input sits half a step above the target code.
	assign comp_i = (trial_code_o <= target);

	sadc_seq u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.standby_i(standby_i), .comp_i(comp_i),
		.trial_code_o(trial_code_o), .channel_select_o(channel_select_o),
		.analog_input_disable_o(analog_input_disable_o),
		.ladder_connect_o(ladder_connect_o), .sample_o(sample_o),
		.conversion_done_irq_o(conversion_done_irq_o));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One classic single cycle; held until ack is sampled high.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 16);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			fails++;
			stop_test();
		end
		@(posedge clk_i);
	endtask

	// Waits a bounded time for the completion pulse.
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (conversion_done_irq_o !== 1'b1 && n < 1400);
		if (conversion_done_irq_o !== 1'b1) begin
			fails++;
			stop_test();
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, unmapped slot and unreadable timing bits.
	task automatic t_reset();
		logic [7:0] q;
		bus(1'b0, A_TIM, 8'h00, q);
		`CHK(q, SADC_TIMING_RST)
		bus(1'b0, A_CTL, 8'h00, q);
		`CHK(q, 8'h00)
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'h00)
		bus(1'b0, 8'h40, 8'h00, q);
		`CHK(q, 8'h00)
		bus(1'b1, A_CTL, 8'h1F, q);
		`CHK(channel_select_o, 4'h7)
		`CHK(analog_input_disable_o, 1'b1)
		bus(1'b0, A_CTL, 8'h00, q);
		`CHK(q, 8'h1F)
		bus(1'b1, A_TIM, 8'hDC, q);
		bus(1'b0, A_TIM, 8'h00, q);
		`CHK(q, 8'h1C)
	endtask

	// Ladder follows the run; its length is the coded time.
	task automatic conv_len(input logic [2:0] code, input int exp);
		logic [7:0] q;
		int n;
		int i;
		n = 0;
		bus(1'b1, A_TIM, {4'h1, code, 1'b0}, q);
		bus(1'b1, A_CTL, 8'hA3, q);
		for (i = 0; i < 1400; i++) begin
			@(posedge clk_i);
			if (ladder_connect_o === 1'b1) n++;
			else if (n > 0) break;
		end
		`CHK(n, exp)
	endtask

	// Single start, early restart, then reads in order.
	task automatic t_single();
		logic [7:0] q;
		target <= 10'h2A5;
		bus(1'b1, A_TIM, 8'h1C, q);
		bus(1'b1, A_CTL, 8'hA3, q);
		`CHK(channel_select_o, 4'h3)
		bus(1'b0, A_CTL, 8'h00, q);
		`CHK(q, 8'h23)
		wait_irq();
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'h60)
		target <= 10'h15A;
		bus(1'b1, A_CTL, 8'hA3, q);
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'h50)
		bus(1'b0, A_UP, 8'h00, q);
		`CHK(q, 8'hA9)
		wait_irq();
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'hA0)
		bus(1'b0, A_UP, 8'h00, q);
		`CHK(q, 8'h56)
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'h80)
	endtask

	// Repeat mode runs on until mode off aborts it.
	task automatic t_repeat();
		logic [7:0] q;
		target <= 10'h0F3;
		bus(1'b1, A_TIM, 8'h1C, q);
		bus(1'b1, A_CTL, 8'hE3, q);
		wait_irq();
		wait_irq();
		target <= 10'h30C;
		repeat (20) @(posedge clk_i);
		bus(1'b1, A_CTL, 8'h03, q);
		repeat (2) @(posedge clk_i);
		`CHK(ladder_connect_o, 1'b0)
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'hE0)
		bus(1'b0, A_UP, 8'h00, q);
		`CHK(q, 8'h3C)
	endtask

	// Standby in mid-run: abort, reset, locked, no restart.
	task automatic t_standby();
		logic [7:0] q;
		int n;
		n = 0;
		bus(1'b1, A_TIM, 8'h3C, q);
		`CHK(ladder_connect_o, 1'b1)
		bus(1'b1, A_CTL, 8'hA5, q);
		repeat (30) @(posedge clk_i);
		standby_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK(ladder_connect_o, 1'b0)
		bus(1'b1, A_TIM, 8'h3A, q);
		bus(1'b0, A_TIM, 8'h00, q);
		`CHK(q, SADC_TIMING_RST)
		bus(1'b0, A_CTL, 8'h00, q);
		`CHK(q, 8'h00)
		bus(1'b0, A_STA, 8'h00, q);
		`CHK(q, 8'h00)
		standby_i <= 1'b0;
		repeat (100) begin
			@(posedge clk_i);
			if (ladder_connect_o !== 1'b0 || sample_o !== 1'b0) n++;
		end
		`CHK(n, 0)
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		conv_len(3'h0, 39);
		conv_len(3'h2, 78);
		conv_len(3'h3, 156);
		conv_len(3'h4, 312);
		conv_len(3'h5, 624);
		conv_len(3'h6, 1248);
		conv_len(3'h7, 1248);
		t_single();
		t_repeat();
		t_standby();
		stop_test();
	end

endmodule // tb_sar_adc_sequencer_control

bind sadc_seq sadc_seq_chk #(.RES_W(RES_W)) u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .standby_i(standby_i), .comp_i(comp_i),
	.trial_code_o(trial_code_o), .channel_select_o(channel_select_o),
	.analog_input_disable_o(analog_input_disable_o),
	.ladder_connect_o(ladder_connect_o), .sample_o(sample_o),
	.conversion_done_irq_o(conversion_done_irq_o));
